/* File: inc/hot_swap_pkg.sv */
package hot_swap_pkg;

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;    // 20 MHz reference clock
    localparam int CNT_W = 18;            // wide enough for the 6.5 ms counts

    // ------------------------------------------------------------
    // documented times, in ns
    // ------------------------------------------------------------
    localparam int POWER_ON_DELAY_NS = 6500000;          // longest allowed
    localparam int PRIMARY_DEFAULT_RESPONSE_NS = 300000; // typical, inside 200..420 us
    localparam int BREAKER_RESET_DELAY_NS = 5000;        // longest allowed
    localparam int ENABLE_LOW_MIN_WIDTH_NS = 200000;     // kept by the host
    localparam int SUPPLY_FILTER_NS = 10000;             // undervoltage_lockout_input and ovp glitch filter
    localparam int POWER_GOOD_FILTER_NS = 30000;         // power-good glitch filter
    localparam int DISCHARGE_DELAY_NS = 250;             // gate off to discharge
    localparam int CAP_SHORT_DETECT_NS = 250;            // shorted timing cap to latch
    localparam int CAP_SHORT_RESUME_NS = 6500000;        // longest allowed
    localparam int FET_SHORT_NS = 10000;                 // drain-gate / drain-source
    localparam int FET_SHORT_STEADY_NS = 250000;         // drain-source after steady state

    // ------------------------------------------------------------
    // derived cycle counts
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] POWER_ON_DELAY_CYCLES = CNT_W'(POWER_ON_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PRIMARY_RESPONSE_CYCLES = CNT_W'(PRIMARY_DEFAULT_RESPONSE_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] BREAKER_RESET_CYCLES = CNT_W'(BREAKER_RESET_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SUPPLY_FILTER_CYCLES = CNT_W'(SUPPLY_FILTER_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] POWER_GOOD_FILTER_CYCLES = CNT_W'(POWER_GOOD_FILTER_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DISCHARGE_DELAY_CYCLES = CNT_W'(DISCHARGE_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CAP_SHORT_DETECT_CYCLES = CNT_W'(CAP_SHORT_DETECT_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CAP_SHORT_RESUME_CYCLES = CNT_W'(CAP_SHORT_RESUME_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] FET_SHORT_CYCLES = CNT_W'(FET_SHORT_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] FET_SHORT_STEADY_CYCLES = CNT_W'(FET_SHORT_STEADY_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ONE_CYCLE = CNT_W'(1);

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] COUNT_RESET = '0;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POWER_ON_WAIT,
        ST_IDLE,
        ST_ON,
        ST_TRIPPED,
        ST_BREAKER_RESET
    } seq_state_t;

endpackage

/* File: rtl/persistence_filter.sv */
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// persistence filter: output follows input only after a change
// has held for the limit; a return before expiry restarts it
// ------------------------------------------------------------
module persistence_filter
    import hot_swap_pkg::*;
#(
    parameter int WIDTH = CNT_W
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic clear_i,
    input wire logic raw_i,
    input wire logic [WIDTH-1:0] rise_limit_i,
    input wire logic [WIDTH-1:0] fall_limit_i,
    output logic level_o
);

    logic level_reg; // filtered level
    logic level_next;
    logic [WIDTH-1:0] cnt_reg; // cycles the input has differed
    logic [WIDTH-1:0] cnt_next;
    logic [WIDTH-1:0] cnt_inc;
    logic [WIDTH-1:0] limit;

    // next-value logic
    always_comb begin
        cnt_inc = cnt_reg + 1'b1;
        limit = raw_i ? rise_limit_i : fall_limit_i;
        level_next = level_reg;
        cnt_next = '0;
        if (clear_i) begin
            // held off: forced low, count idle
            level_next = 1'b0;
        end else if (raw_i != level_reg) begin
            if (cnt_inc >= limit) begin
                level_next = raw_i;
            end else begin
                cnt_next = cnt_inc;
            end
        end
        // an input back at the old level leaves cnt_next at zero
    end

    // registers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            level_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            level_reg <= level_next;
            cnt_reg <= cnt_next;
        end
    end

    assign level_o = level_reg;

endmodule

`default_nettype wire

/* File: rtl/hot_swap_fault_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - regulator lockout holds everything reset and inactive except the gate pull-down
// - regulator good starts bounded power-on delay
// - delay end arms machines and short detectors
// - start on enable rise or already high
// - primary overcurrent tolerated for its period
// - secondary overcurrent trips without qualification delay
// - power good needs output and gate-source good
// - floating timing cap uses default response
// - enable low resets breaker within 5 us
// - undervoltage_lockout_input and ovp filtered about 10 us
// - power-good comparator filtered about 30 us
// - discharge follows a fault gate-off by 0.25 us
// - shorted timing cap latches hardware fault
// - cap short detection resumes within 6.5 ms
// - drain-gate short latches fault after 10 us
// - drain-source short latches fault after 10 us
// - drain-source short after steady state: 250 us
// - trip: gate off, discharge, current fault latched
// - enable fall resets either breaker trip
module hot_swap_fault_sequencer
    import hot_swap_pkg::*;
#(
    parameter logic [CNT_W-1:0] POWER_ON_CYCLES_P = POWER_ON_DELAY_CYCLES,
    parameter logic [CNT_W-1:0] PRIMARY_CYCLES_P = PRIMARY_RESPONSE_CYCLES,
    parameter logic [CNT_W-1:0] CAP_RESUME_CYCLES_P = CAP_SHORT_RESUME_CYCLES,
    parameter logic [CNT_W-1:0] FET_STEADY_CYCLES_P = FET_SHORT_STEADY_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic internal_regulator_voltage_ok_i, // regulator above lockout
    input wire logic enable_i,
    input wire logic secondary_threshold_select_hi_i,
    input wire logic secondary_threshold_select_lo_i,
    input wire logic [3:0] secondary_oc_levels_i, // one comparator per threshold
    input wire logic primary_oc_i, // sense above primary threshold
    input wire logic primary_timing_cap_pin_low_i, // cap pin below its low threshold
    input wire logic undervoltage_lockout_input_i, // high: supply above undervoltage_lockout_input
    input wire logic overvoltage_input_i, // high: supply above ovp
    input wire logic vout_above_high_i,
    input wire logic vout_above_low_i,
    input wire logic vgs_above_good_i,
    input wire logic gate_to_ground_fault_i,
    input wire logic source_to_ground_fault_i,
    output logic gate_drive_o,
    output logic gate_fault_pulldown_o,
    output logic primary_cap_sink_o,
    output logic output_discharge_drive_o,
    output logic current_fault_flag_o,
    output logic power_good_flag_o,
    output logic hardware_fault_flag_o
);

    // ------------------------------------------------------------
    // state and wires
    // ------------------------------------------------------------
    seq_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next; // power-on and breaker reset timing
    logic gate_reg, gate_next; // gate charge pump enable
    logic cur_fault_reg, cur_fault_next; // latched breaker trip
    logic cap_sink_reg, cap_sink_next; // timing cap discharge sink
    logic [CNT_W-1:0] blank_reg, blank_next; // cap short detection blanking
    logic steady_reg, steady_next; // enable fell while power was good
    logic hw_fault_reg, hw_fault_next; // hardware fault latch
    logic active; // power-on delay over, regulator good
    logic lockout;
    logic uv_ok_filt, ov_filt, supply_ok;
    logic sec_oc;
    logic prim_expired;
    logic pg_target, pg_flag;
    logic output_discharge_drive_level;
    logic cap_short, dg_short, ds_short;
    logic fet_check;
    logic [CNT_W-1:0] ds_limit;

    assign lockout = !internal_regulator_voltage_ok_i;
    assign active = (state_reg != ST_POWER_ON_WAIT) && !lockout;
    assign supply_ok = uv_ok_filt && !ov_filt;
    // the threshold itself is analog; here the select picks its comparator
    assign sec_oc = secondary_oc_levels_i[{secondary_threshold_select_hi_i, secondary_threshold_select_lo_i}];

    // ------------------------------------------------------------
    // supply monitor glitch filters
    // ------------------------------------------------------------
    persistence_filter #(.WIDTH(CNT_W)) uv_filter (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(!active),
        .raw_i(undervoltage_lockout_input_i),
        .rise_limit_i(SUPPLY_FILTER_CYCLES),
        .fall_limit_i(SUPPLY_FILTER_CYCLES),
        .level_o(uv_ok_filt)
    );

    persistence_filter #(.WIDTH(CNT_W)) ov_filter (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(!active),
        .raw_i(overvoltage_input_i),
        .rise_limit_i(SUPPLY_FILTER_CYCLES),
        .fall_limit_i(SUPPLY_FILTER_CYCLES),
        .level_o(ov_filt)
    );

    // ------------------------------------------------------------
    // primary overcurrent timer
    // ------------------------------------------------------------
    // runs only while sense is high and the cap has reached its low
    // threshold; a floating pin is low at once, leaving the default time
    persistence_filter #(.WIDTH(CNT_W)) primary_timer (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(state_reg != ST_ON),
        .raw_i(cap_sink_reg && primary_oc_i && primary_timing_cap_pin_low_i),
        .rise_limit_i(PRIMARY_CYCLES_P),
        .fall_limit_i(ONE_CYCLE),
        .level_o(prim_expired)
    );

    // ------------------------------------------------------------
    // power-good filter with hysteresis
    // ------------------------------------------------------------
    always_comb begin
        if (pg_flag) begin
            pg_target = vout_above_low_i && vgs_above_good_i;
        end else begin
            pg_target = !cur_fault_reg && vout_above_high_i && vgs_above_good_i;
        end
    end

    persistence_filter #(.WIDTH(CNT_W)) pg_filter (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(!active),
        .raw_i(pg_target),
        .rise_limit_i(POWER_GOOD_FILTER_CYCLES),
        .fall_limit_i(POWER_GOOD_FILTER_CYCLES),
        .level_o(pg_flag)
    );

    // ------------------------------------------------------------
    // discharge delay after a fault turn-off
    // ------------------------------------------------------------
    persistence_filter #(.WIDTH(CNT_W)) output_discharge_drive_delay (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(!active),
        .raw_i(cur_fault_reg && !gate_reg),
        .rise_limit_i(DISCHARGE_DELAY_CYCLES),
        .fall_limit_i(ONE_CYCLE),
        .level_o(output_discharge_drive_level)
    );

    // ------------------------------------------------------------
    // hardware fault detectors
    // ------------------------------------------------------------
    // transistor shorts are only meaningful with the gate held off
    assign fet_check = active && !enable_i && !gate_reg;
    assign ds_limit = steady_reg ? FET_STEADY_CYCLES_P : FET_SHORT_CYCLES;

    persistence_filter #(.WIDTH(CNT_W)) cap_short_filter (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(!active || cap_sink_reg || (blank_reg != COUNT_RESET)),
        .raw_i(primary_timing_cap_pin_low_i),
        .rise_limit_i(CAP_SHORT_DETECT_CYCLES),
        .fall_limit_i(ONE_CYCLE),
        .level_o(cap_short)
    );

    persistence_filter #(.WIDTH(CNT_W)) dg_filter (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(!fet_check),
        .raw_i(gate_to_ground_fault_i),
        .rise_limit_i(FET_SHORT_CYCLES),
        .fall_limit_i(ONE_CYCLE),
        .level_o(dg_short)
    );

    persistence_filter #(.WIDTH(CNT_W)) ds_filter (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(!fet_check),
        .raw_i(source_to_ground_fault_i),
        .rise_limit_i(ds_limit),
        .fall_limit_i(ONE_CYCLE),
        .level_o(ds_short)
    );

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = COUNT_RESET;
        gate_next = 1'b0;
        cur_fault_next = cur_fault_reg;
        cap_sink_next = 1'b0;
        blank_next = blank_reg;
        steady_next = steady_reg;
        hw_fault_next = hw_fault_reg;
        if (blank_reg != COUNT_RESET) begin
            blank_next = blank_reg - 1'b1;
        end
        if (cap_short || dg_short || ds_short) begin
            hw_fault_next = 1'b1;
        end
        if (enable_i) begin
            steady_next = 1'b0;
        end
        unique case (state_reg)
            ST_POWER_ON_WAIT: begin
                // enable sampled at expiry acts as a rising edge
                if (cnt_reg + 1'b1 >= POWER_ON_CYCLES_P) begin
                    state_next = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            ST_IDLE: begin
                // idle is entered with enable low except at power-on end or on a supply fault
                if (enable_i && supply_ok) begin
                    state_next = ST_ON;
                    gate_next = 1'b1;
                end
            end
            ST_ON: begin
                if (sec_oc || prim_expired) begin
                    // immediate turn-off, no qualification on the fast path
                    state_next = ST_TRIPPED;
                    cur_fault_next = 1'b1;
                end else if (!enable_i || !supply_ok) begin
                    state_next = ST_IDLE;
                    steady_next = !enable_i && pg_flag;
                end else begin
                    gate_next = 1'b1;
                    cap_sink_next = primary_oc_i;
                    if (primary_oc_i && !cap_sink_reg) begin
                        blank_next = CAP_RESUME_CYCLES_P;
                    end
                end
            end
            ST_TRIPPED: begin
                if (!enable_i) begin
                    state_next = ST_BREAKER_RESET;
                end
            end
            ST_BREAKER_RESET: begin
                // the reset delay is counted from the enable fall
                if (cnt_reg + 1'b1 >= BREAKER_RESET_CYCLES) begin
                    state_next = ST_IDLE;
                    cur_fault_next = 1'b0;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
        endcase
        if (lockout) begin
            // regulator low overrides everything, including latches
            state_next = ST_POWER_ON_WAIT;
            cnt_next = COUNT_RESET;
            gate_next = 1'b0;
            cur_fault_next = 1'b0;
            cap_sink_next = 1'b0;
            blank_next = COUNT_RESET;
            steady_next = 1'b0;
            hw_fault_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_POWER_ON_WAIT;
            cnt_reg <= COUNT_RESET;
            gate_reg <= 1'b0;
            cur_fault_reg <= 1'b0;
            cap_sink_reg <= 1'b0;
            blank_reg <= COUNT_RESET;
            steady_reg <= 1'b0;
            hw_fault_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            gate_reg <= gate_next;
            cur_fault_reg <= cur_fault_next;
            cap_sink_reg <= cap_sink_next;
            blank_reg <= blank_next;
            steady_reg <= steady_next;
            hw_fault_reg <= hw_fault_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign gate_drive_o = gate_reg;
    // strong pull-down while tripped or in the power-on wait, which a low regulator forces
    assign gate_fault_pulldown_o = cur_fault_reg || (state_reg == ST_POWER_ON_WAIT);
    assign primary_cap_sink_o = cap_sink_reg;
    assign output_discharge_drive_o = output_discharge_drive_level;
    assign current_fault_flag_o = cur_fault_reg;
    assign power_good_flag_o = pg_flag;
    assign hardware_fault_flag_o = hw_fault_reg;

endmodule

`default_nettype wire

/* File: verification/hot_swap_fault_sequencer_props.sv */
`timescale 1ns/1ns
`default_nettype none

// --------------------------------
// port-level checks of the fault sequencer
// --------------------------------
module hot_swap_fault_sequencer_props
    import hot_swap_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic internal_regulator_voltage_ok_i,
    input wire logic enable_i,
    input wire logic secondary_threshold_select_hi_i,
    input wire logic secondary_threshold_select_lo_i,
    input wire logic [3:0] secondary_oc_levels_i,
    input wire logic primary_oc_i,
    input wire logic vout_above_high_i,
    input wire logic vgs_above_good_i,
    input wire logic gate_drive_o,
    input wire logic output_discharge_drive_o,
    input wire logic current_fault_flag_o,
    input wire logic power_good_flag_o,
    input wire logic hardware_fault_flag_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_lockout;
        !internal_regulator_voltage_ok_i |=> !gate_drive_o && !current_fault_flag_o && !power_good_flag_o
            && !hardware_fault_flag_o;
    endproperty
    a_lockout: assert property (p_lockout) else $error("output active in lockout");
    property p_power_on;
        $rose(internal_regulator_voltage_ok_i) |=> !gate_drive_o [*8];
    endproperty
    a_power_on: assert property (p_power_on) else $error("gate on during power-on wait");
    // the selected comparator alone decides a fast trip
    property p_secondary;
        gate_drive_o && enable_i && internal_regulator_voltage_ok_i
            && secondary_oc_levels_i[{secondary_threshold_select_hi_i, secondary_threshold_select_lo_i}]
            |-> ##[1:10] (!gate_drive_o && current_fault_flag_o);
    endproperty
    a_secondary: assert property (p_secondary) else $error("secondary trip late");
    property p_discharge;
        $rose(output_discharge_drive_o) |-> !gate_drive_o && $past(current_fault_flag_o, 4);
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge too early");
    property p_output_discharge_drive_on;
        current_fault_flag_o [*8] |-> output_discharge_drive_o;
    endproperty
    a_output_discharge_drive_on: assert property (p_output_discharge_drive_on) else $error("discharge missing on trip");
    property p_breaker;
        $fell(enable_i) && current_fault_flag_o |-> ##[1:110] !current_fault_flag_o;
    endproperty
    a_breaker: assert property (p_breaker) else $error("breaker not reset");
    property p_pg_cause;
        $rose(power_good_flag_o) |-> !current_fault_flag_o && $past(vout_above_high_i, 4)
            && $past(vgs_above_good_i, 4);
    endproperty
    a_pg_cause: assert property (p_pg_cause) else $error("power good without cause");
    property p_pg_filter;
        $rose(vout_above_high_i) && !power_good_flag_o |=> !power_good_flag_o [*8];
    endproperty
    a_pg_filter: assert property (p_pg_filter) else $error("power good unfiltered");
    property p_primary;
        $rose(primary_oc_i) && gate_drive_o && enable_i && secondary_oc_levels_i == 4'h0 |=> gate_drive_o [*8];
    endproperty
    a_primary: assert property (p_primary) else $error("primary trip too fast");
endmodule

`default_nettype wire

/* File: verification/hot_swap_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// --------------------------------
// host enable driver and floating timing cap pin
// --------------------------------
module hot_swap_host_model
    import hot_swap_pkg::*;
#(
    parameter int LOW_MIN = ENABLE_LOW_MIN_WIDTH_NS / CLK_PERIOD_NS
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic enable_req_i,
    input wire logic cap_short_i,
    input wire logic primary_cap_sink_i,
    output logic enable_o,
    output logic cap_low_o
);
    int low_cnt_reg; // cycles enable has stood low, saturating
    int low_cnt_next;
    logic enable_next;
    // a rise waits out the low time, so a quick bench toggle cannot break it
    always_comb begin
        low_cnt_next = enable_o ? 0 : (low_cnt_reg < LOW_MIN ? low_cnt_reg + 1 : low_cnt_reg);
        enable_next = enable_req_i && (enable_o || low_cnt_reg >= LOW_MIN);
    end
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            low_cnt_reg <= LOW_MIN;
            enable_o <= 1'b0;
        end else begin
            low_cnt_reg <= low_cnt_next;
            enable_o <= enable_next;
        end
    end
    // floating cap drops below threshold once the sink pulls; a short holds it low
    assign cap_low_o = primary_cap_sink_i | cap_short_i;
endmodule

`default_nettype wire

/* File: verification/hot_swap_fault_sequencer_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module hot_swap_fault_sequencer_tb
    import hot_swap_pkg::*;
;
    localparam int PRI = 30; // shortened primary response
    logic clk, rst, reg_ok, en_req, en, hi, lo, poc, cshort, clow, uv, ov, vh, vl, vgs, gg, sg;
    logic [3:0] lev;
    logic gate, gpd, sink, output_discharge_drive, flt, pg, hw;
    int bad_count, checks, n;

    hot_swap_fault_sequencer #(.POWER_ON_CYCLES_P(CNT_W'(20)), .PRIMARY_CYCLES_P(CNT_W'(PRI)),
        .CAP_RESUME_CYCLES_P(CNT_W'(40)), .FET_STEADY_CYCLES_P(CNT_W'(50))) DUT (
        .ref_clk_i(clk), .sys_rst_i(rst), .internal_regulator_voltage_ok_i(reg_ok), .enable_i(en),
        .secondary_threshold_select_hi_i(hi), .secondary_threshold_select_lo_i(lo),
        .secondary_oc_levels_i(lev), .primary_oc_i(poc), .primary_timing_cap_pin_low_i(clow),
        .undervoltage_lockout_input_i(uv), .overvoltage_input_i(ov), .vout_above_high_i(vh),
        .vout_above_low_i(vl), .vgs_above_good_i(vgs), .gate_to_ground_fault_i(gg),
        .source_to_ground_fault_i(sg), .gate_drive_o(gate), .gate_fault_pulldown_o(gpd),
        .primary_cap_sink_o(sink), .output_discharge_drive_o(output_discharge_drive), .current_fault_flag_o(flt),
        .power_good_flag_o(pg), .hardware_fault_flag_o(hw));
    hot_swap_host_model u_host (.ref_clk_i(clk), .sys_rst_i(rst), .enable_req_i(en_req),
        .cap_short_i(cshort), .primary_cap_sink_i(sink), .enable_o(en), .cap_low_o(clow));

    always #25 clk = ~clk;

    // --------------------------------
    // shared helpers
    // --------------------------------
    task tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task check(input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %b, wanted %b", $time, seen, exp);
        end
    endtask
    task report_and_stop();
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic pick(input int w);
        return w == 0 ? gate : (w == 1 ? flt : pg);
    endfunction
    // bounded wait for an output level; n holds the cycles it took
    task wait_for(input int w, input logic lvl, input int max);
        n = 0;
        while (pick(w) !== lvl) begin
            tick(1);
            n++;
            if (n > max) begin
                bad_count++;
                $display("mismatch at %0t: wait ran out", $time);
                report_and_stop();
            end
        end
    endtask
    // clear a trip by an enable fall, then bring the channel back up
    task reset_breaker();
        en_req = 1'b0;
        wait_for(1, 1'b0, 120);
        check(n <= int'(BREAKER_RESET_CYCLES) + 3, 1'b1);
        en_req = 1'b1;
        wait_for(0, 1'b1, 4500);
        check(n >= 3800, 1'b1);
    endtask

    // --------------------------------
    // scenarios
    // --------------------------------
    task t_power_on();
        tick(8);
        check({gate, flt, hw, gpd} === 4'h1, 1'b1);
        wait_for(0, 1'b1, 260);
        check(gate, 1'b1);
    endtask
    task t_power_good();
        vh = 1'b1;
        vl = 1'b1;
        tick(700);
        check(pg, 1'b0);
        vgs = 1'b1;
        wait_for(2, 1'b1, 700);
        check(n >= 590, 1'b1);
    endtask
    // unselected comparators must not trip; each select value is tried
    task t_secondary();
        for (int s = 0; s < 4; s++) begin
            {hi, lo} = 2'(s);
            lev = ~(4'h1 << s);
            tick(3);
            check(gate, 1'b1);
            lev = 4'hf;
            tick(2);
            check({gate, flt, gpd} === 3'b011, 1'b1);
            tick(8);
            check(output_discharge_drive, 1'b1);
            lev = 4'h0;
            vl = 1'b0;
            tick(700);
            check(pg, 1'b0);
            vl = 1'b1;
            reset_breaker();
        end
    endtask
    task t_primary();
        poc = 1'b1;
        tick(2);
        check(sink, 1'b1);
        wait_for(0, 1'b0, 60);
        check(n >= PRI - 1 && n <= PRI + 4, 1'b1);
        check({flt, sink} === 2'b10, 1'b1);
        poc = 1'b0;
        reset_breaker();
    endtask
    // a short dip is ignored; a fresh long dip restarts the filter count
    task t_supply();
        uv = 1'b0;
        tick(100);
        check(gate, 1'b1);
        uv = 1'b1;
        tick(5);
        uv = 1'b0;
        wait_for(0, 1'b0, 260);
        check(n >= 190 && flt === 1'b0, 1'b1);
        uv = 1'b1;
        wait_for(0, 1'b1, 260);
        ov = 1'b1;
        wait_for(0, 1'b0, 260);
        check(n >= 190, 1'b1);
        ov = 1'b0;
        wait_for(0, 1'b1, 260);
    endtask
    task t_hw();
        // turn-off from steady state picks the drain-source steady filter
        en_req = 1'b0;
        sg = 1'b1;
        tick(45);
        check(hw, 1'b0);
        tick(15);
        check(hw, 1'b1);
        sg = 1'b0;
        en_req = 1'b1;
        wait_for(0, 1'b1, 4500);
        reg_ok = 1'b0;
        tick(2);
        reg_ok = 1'b1;
        wait_for(0, 1'b1, 260);
        gg = 1'b1;
        tick(300);
        check(hw, 1'b0);
        gg = 1'b0;
        cshort = 1'b1;
        tick(10);
        check(hw, 1'b1);
        cshort = 1'b0;
        en_req = 1'b0;
        for (int k = 0; k < 2; k++) begin
            reg_ok = 1'b0;
            tick(2);
            check(hw, 1'b0);
            reg_ok = 1'b1;
            tick(30);
            {gg, sg} = k ? 2'b01 : 2'b10;
            tick(150);
            check(hw, 1'b0);
            tick(60);
            check(hw, 1'b1);
            {gg, sg} = 2'b00;
        end
    endtask

    initial begin
        clk = 1'b0;
        {rst, reg_ok, en_req, uv} = 4'hf;
        {hi, lo, poc, cshort, ov, vh, vl, vgs, gg, sg, lev} = '0;
        tick(3);
        rst = 1'b0;
        t_power_on();
        t_power_good();
        t_secondary();
        t_primary();
        t_supply();
        t_hw();
        report_and_stop();
    end
endmodule

bind hot_swap_fault_sequencer hot_swap_fault_sequencer_props u_props (.ref_clk_i, .sys_rst_i,
    .internal_regulator_voltage_ok_i, .enable_i, .secondary_threshold_select_hi_i,
    .secondary_threshold_select_lo_i, .secondary_oc_levels_i, .primary_oc_i, .vout_above_high_i,
    .vgs_above_good_i, .gate_drive_o, .output_discharge_drive_o, .current_fault_flag_o,
    .power_good_flag_o, .hardware_fault_flag_o);

`default_nettype wire
